// ---- flash_iap_consts.svh ----
`ifndef FLASH_IAP_CONSTS_SVH
`define FLASH_IAP_CONSTS_SVH
// register byte offsets on the apb bus
`define OFS_CONTROL      12'h000
`define OFS_BUF_CLEAR    12'h004
`define OFS_TARGET_LOW   12'h008
`define OFS_TARGET_HIGH  12'h00c
`define OFS_DATA0_LOW    12'h010
`define OFS_DATA0_HIGH   12'h014
`define OFS_KEY1_LOW     12'h018
`define OFS_KEY1_HIGH    12'h01c
`define OFS_KEY2_LOW     12'h020
`define OFS_KEY2_HIGH    12'h024
`define OFS_KEY3_LOW     12'h028
`define OFS_KEY3_HIGH    12'h02c
// control register field positions
`define BIT_UNLOCKED     7
`define BIT_OPSEL_HI     6
`define BIT_OPSEL_LO     4
`define BIT_TRIGGER      3
`define BIT_PROGRAM_GO   2
`define BIT_READ_PERMIT  1
`define BIT_READ_GO      0
// operation select codes
`define OP_WRITE         3'b000
`define OP_ERASE         3'b001
`define OP_READ          3'b011
`define OP_UNLOCK        3'b110
// unlock key bytes
`define KEY1_LOW         8'h00
`define KEY2_LOW         8'h0d
`define KEY3_LOW         8'hc3
`define KEY1_HIGH        8'h04
`define KEY2_HIGH        8'h09
`define KEY3_HIGH        8'h40
// timing
`define CLK_PERIOD_NS    10
`define PROGRAM_TIME_NS  2200000
`define PROGRAM_CYCLES   (`PROGRAM_TIME_NS / `CLK_PERIOD_NS)
`define READ_CYCLES      3
`define UNLOCK_CYCLES    64
`endif

// ---- flash_iap_pkg.sv ----
package flash_iap_pkg;
	typedef enum logic [1:0] {OP_IDLE, OP_PROGRAM, OP_READING, OP_CLEARING} op_state_e;
	typedef struct packed {
		logic       unlocked;
		logic [2:0] opsel;
		logic       trigger;
		logic       program_go;
		logic       read_permit;
		logic       read_go;
	} control_s;
	typedef struct packed {
		logic        we;
		logic [12:0] addr;
		logic [15:0] wdata;
	} flash_req_s;
endpackage

// ---- flash_iap_erase_write_read.sv ----
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "flash_iap_consts.svh"

// Summary of operation
// - correct key during window sets unlocked flag; erase and write need it
// - setting trigger starts the key acceptance window timer
// - key bytes 00 0d c3 low and 04 09 40 high are compared
// - trigger bit clears by hardware at timer expiry regardless of key
// - wrong key leaves flash locked; firmware repeats procedure
// - firmware clearing unlocked flag relocks at once
// - 32 word buffer maps to page chosen by address bits 12 to 5
// - each high byte write stores the word and advances pointer
// - pointer holds at last word of the page
// - opsel 001 with program go erases the whole page, then clears go
// - opsel 000 with program go writes buffer to page, then clears go
// - erase or write lasts 2.2 ms from go set to go clear
// - cpu stalls while an erase or write runs
// - erase always acts on a whole page
// - buffer clear allows rewriting an unerased page
// - read with opsel 011 and permit returns word in data pair zero
// - read needs no unlock
// - read stalls cpu three cycles then clears read go
// - software writes of one to unlocked flag are ignored
// - buffer clear go self clears when buffer is cleared
module flash_iap_erase_write_read #(
	parameter int PROGRAM_CYCLES = `PROGRAM_CYCLES,
	parameter int UNLOCK_CYCLES  = `UNLOCK_CYCLES
) (
	input  wire logic                       clk,
	input  wire logic                       rstn,
	input  wire logic                       ce,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	output logic                            cpu_stall,
	output flash_iap_pkg::flash_req_s       flash_req,
	output logic                            flash_req_valid,
	output logic                            flash_page_erase,
	output logic      [7:0]                 flash_page,
	input  wire logic [15:0]                flash_rdata
);
	import flash_iap_pkg::*;

	// refuse counts that the timer or window widths cannot hold
	if (PROGRAM_CYCLES < 32 || PROGRAM_CYCLES > 4194303
		|| UNLOCK_CYCLES < 2 || UNLOCK_CYCLES > 127)
	begin
		$error("cycle counts out of range");
	end

	// ****************************************
	// state
	// ****************************************
	control_s    ctl, next_ctl;
	logic        clr_go, next_clr_go;
	logic [7:0]  tlow, next_tlow, thigh, next_thigh;
	logic [7:0]  d0l, next_d0l, d0h, next_d0h;
	logic [7:0]  key [0:5];
	logic [7:0]  next_key [0:5];
	logic [15:0] buffer [0:31];
	logic [15:0] next_buffer [0:31];
	logic [4:0]  word_ptr, next_word_ptr;
	op_state_e   state, next_state;
	logic [21:0] timer, next_timer;
	logic [6:0]  win, next_win;
	logic [5:0]  sub, next_sub;
	logic [31:0] next_prdata;
	logic        next_pready, next_pslverr, next_stall;
	flash_req_s  next_req;
	logic        next_req_valid, next_erase;
	logic [7:0]  next_page;

	function automatic logic key_ok(input logic [7:0] k [0:5]);
		key_ok = k[0] == `KEY1_LOW && k[1] == `KEY1_HIGH && k[2] == `KEY2_LOW
			&& k[3] == `KEY2_HIGH && k[4] == `KEY3_LOW && k[5] == `KEY3_HIGH;
	endfunction

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = a == o;
	endfunction

	wire logic       wr_acc = psel && penable && pwrite && !pready;
	wire logic       rd_acc = psel && penable && !pwrite && !pready;
	wire logic [7:0] wb     = pwdata[7:0];
	wire logic [12:0] taddr = {thigh[4:0], tlow};

	// ****************************************
	// next values
	// ****************************************
	always_comb
	begin
		next_ctl = ctl;
		next_clr_go = clr_go;
		next_tlow = tlow;
		next_thigh = thigh;
		next_d0l = d0l;
		next_d0h = d0h;
		next_key = key;
		next_buffer = buffer;
		next_word_ptr = word_ptr;
		next_state = state;
		next_timer = timer;
		next_win = win;
		next_sub = sub;
		next_prdata = 32'h0;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		next_req = flash_req;
		next_req_valid = 1'b0;
		next_erase = 1'b0;
		next_page = taddr[12:5];
		if (wr_acc)
		begin
			next_pready = 1'b1;
			case (paddr)
				`OFS_CONTROL:
				begin
					next_ctl.unlocked = ctl.unlocked & pwdata[`BIT_UNLOCKED];
					next_ctl.opsel = pwdata[`BIT_OPSEL_HI:`BIT_OPSEL_LO];
					next_ctl.read_permit = pwdata[`BIT_READ_PERMIT];
					if (pwdata[`BIT_TRIGGER] && !ctl.trigger
						&& pwdata[`BIT_OPSEL_HI:`BIT_OPSEL_LO] == `OP_UNLOCK)
					begin
						next_ctl.trigger = 1'b1;
						next_win = 7'(UNLOCK_CYCLES);
						for (int i = 0; i < 6; i++)
							next_key[i] = 8'h00;
					end
					if (state == OP_IDLE && pwdata[`BIT_PROGRAM_GO])
					begin
						if (ctl.unlocked && (pwdata[6:4] == `OP_WRITE || pwdata[6:4] == `OP_ERASE))
						begin
							next_ctl.program_go = 1'b1;
							next_state = OP_PROGRAM;
							next_timer = 22'(PROGRAM_CYCLES);
						end
					end
					else if (state == OP_IDLE && pwdata[`BIT_READ_GO])
					begin
						if (pwdata[`BIT_READ_PERMIT] && pwdata[6:4] == `OP_READ)
						begin
							next_ctl.read_go = 1'b1;
							next_state = OP_READING;
							next_timer = 22'(`READ_CYCLES);
						end
					end
				end
				`OFS_BUF_CLEAR:
					if (wb[0] && state == OP_IDLE)
					begin
						next_clr_go = 1'b1;
						next_state = OP_CLEARING;
						next_sub = 6'h00;
					end
				`OFS_TARGET_LOW:
				begin
					next_tlow = wb;
					next_word_ptr = wb[4:0];
				end
				`OFS_TARGET_HIGH: next_thigh = wb;
				`OFS_DATA0_LOW: next_d0l = wb;
				`OFS_DATA0_HIGH:
				begin
					next_d0h = wb;
					next_buffer[word_ptr] = {wb, d0l};
					if (word_ptr != 5'h1f)
						next_word_ptr = 5'(word_ptr + 5'h01);
				end
				`OFS_KEY1_LOW: next_key[0] = wb;
				`OFS_KEY1_HIGH: next_key[1] = wb;
				`OFS_KEY2_LOW: next_key[2] = wb;
				`OFS_KEY2_HIGH: next_key[3] = wb;
				`OFS_KEY3_LOW: next_key[4] = wb;
				`OFS_KEY3_HIGH: next_key[5] = wb;
				default: next_pslverr = 1'b1;
			endcase
		end
		else if (rd_acc)
		begin
			next_pready = 1'b1;
			case (paddr)
				`OFS_CONTROL: next_prdata = {24'h0, ctl};
				`OFS_BUF_CLEAR: next_prdata = {31'h0, clr_go};
				`OFS_TARGET_LOW: next_prdata = {24'h0, tlow};
				`OFS_TARGET_HIGH: next_prdata = {24'h0, thigh};
				`OFS_DATA0_LOW: next_prdata = {24'h0, d0l};
				`OFS_DATA0_HIGH: next_prdata = {24'h0, d0h};
				`OFS_KEY1_LOW: next_prdata = {24'h0, key[0]};
				`OFS_KEY1_HIGH: next_prdata = {24'h0, key[1]};
				`OFS_KEY2_LOW: next_prdata = {24'h0, key[2]};
				`OFS_KEY2_HIGH: next_prdata = {24'h0, key[3]};
				`OFS_KEY3_LOW: next_prdata = {24'h0, key[4]};
				`OFS_KEY3_HIGH: next_prdata = {24'h0, key[5]};
				default: next_pslverr = 1'b1;
			endcase
		end
		if (ctl.trigger)
		begin
			if (win == 7'h01)
			begin
				next_ctl.trigger = 1'b0;
				if (key_ok(next_key) && ctl.opsel == `OP_UNLOCK)
					next_ctl.unlocked = 1'b1;
			end
			else
				next_win = 7'(win - 7'h01);
		end
		case (state)
			OP_IDLE: ;
			OP_PROGRAM:
			begin
				if (timer == 22'h1)
				begin
					next_ctl.program_go = 1'b0;
					next_state = OP_IDLE;
					next_erase = ctl.opsel == `OP_ERASE;
				end
				else
					next_timer = 22'(timer - 22'h1);
				if (ctl.opsel == `OP_WRITE && timer <= 22'd32)
				begin
					next_req.we = 1'b1;
					next_req.addr = {taddr[12:5], 5'(22'd32 - timer)};
					next_req.wdata = buffer[5'(22'd32 - timer)];
					next_req_valid = 1'b1;
				end
			end
			OP_READING:
			begin
				next_req.we = 1'b0;
				next_req.addr = taddr;
				next_req.wdata = 16'h0;
				next_req_valid = timer == 22'(`READ_CYCLES);
				if (timer == 22'h1)
				begin
					next_d0l = flash_rdata[7:0];
					next_d0h = flash_rdata[15:8];
					next_ctl.read_go = 1'b0;
					next_state = OP_IDLE;
				end
				else
					next_timer = 22'(timer - 22'h1);
			end
			OP_CLEARING:
			begin
				next_buffer[sub[4:0]] = 16'h0000;
				if (sub == 6'h1f)
				begin
					next_clr_go = 1'b0;
					next_state = OP_IDLE;
				end
				else
					next_sub = 6'(sub + 6'h01);
			end
			default: next_state = OP_IDLE;
		endcase
		next_stall = next_state == OP_PROGRAM || next_state == OP_READING;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			ctl <= '0;
			clr_go <= 1'b0;
			tlow <= 8'h00;
			thigh <= 8'h00;
			d0l <= 8'h00;
			d0h <= 8'h00;
			for (int i = 0; i < 6; i++)
				key[i] <= 8'h00;
			for (int i = 0; i < 32; i++)
				buffer[i] <= 16'h0000;
			word_ptr <= 5'h00;
			state <= OP_IDLE;
			timer <= 22'h0;
			win <= 7'h0;
			sub <= 6'h0;
			prdata <= 32'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			cpu_stall <= 1'b0;
			flash_req <= '0;
			flash_req_valid <= 1'b0;
			flash_page_erase <= 1'b0;
			flash_page <= 8'h00;
		end
		else if (ce)
		begin
			ctl <= next_ctl;
			clr_go <= next_clr_go;
			tlow <= next_tlow;
			thigh <= next_thigh;
			d0l <= next_d0l;
			d0h <= next_d0h;
			key <= next_key;
			buffer <= next_buffer;
			word_ptr <= next_word_ptr;
			state <= next_state;
			timer <= next_timer;
			win <= next_win;
			sub <= next_sub;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			cpu_stall <= next_stall;
			flash_req <= next_req;
			flash_req_valid <= next_req_valid;
			flash_page_erase <= next_erase;
			flash_page <= next_page;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	sequence read_start;
		$rose(ctl.read_go);
	endsequence

	no_sw_unlock_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(ctl.unlocked) |-> $past(ctl.trigger) && $past(win) == 7'h01)
		else $error("unlocked set outside key check");
	trigger_expiry_a: assert property (@(posedge clk) disable iff (!rstn)
		ce && ctl.trigger && win == 7'h01 |=> !ctl.trigger)
		else $error("trigger did not clear at expiry");
	locked_go_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(ctl.program_go) |-> $past(ctl.unlocked))
		else $error("program go accepted while locked");
	ptr_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		ce && wr_acc && hit(paddr, `OFS_DATA0_HIGH) && word_ptr == 5'h1f |=> word_ptr == 5'h1f)
		else $error("pointer crossed page end");
	ptr_step_a: assert property (@(posedge clk) disable iff (!rstn)
		ce && wr_acc && hit(paddr, `OFS_DATA0_HIGH) && word_ptr != 5'h1f
		|=> word_ptr == $past(word_ptr) + 5'h01)
		else $error("pointer did not advance");
	read_len_a: assert property (@(posedge clk) disable iff (!rstn)
		read_start ##0 ce [*3] |=> !ctl.read_go)
		else $error("read go not cleared after three cycles");
	stall_go_a: assert property (@(posedge clk) disable iff (!rstn)
		ctl.program_go |-> cpu_stall)
		else $error("cpu not stalled during program");
	clear_done_a: assert property (@(posedge clk) disable iff (!rstn)
		$rose(clr_go) ##0 ce [*8] |-> clr_go)
		else $error("buffer clear ended early");
	relock_a: assert property (@(posedge clk) disable iff (!rstn)
		ce && wr_acc && paddr == `OFS_CONTROL && !pwdata[7] && !ctl.trigger |=> !ctl.unlocked)
		else $error("unlocked flag not cleared");
endmodule

// ---- test_flash_iap_erase_write_read.sv ----
`timescale 1ns/100ps
`include "flash_iap_consts.svh"
`define CHK(got, want) begin cmp_count++; if ((got) !== (want)) begin failures++; $display("unexpected at %0t: got %h expected %h", $time, got, want); end end
module test_flash_iap_erase_write_read;
	import flash_iap_pkg::*;
	localparam int PC = 40;
	localparam int UC = 64;
	logic             clk, rstn, ce, psel, penable, pwrite, pready, pslverr, cpu_stall;
	logic [11:0]      paddr;
	logic [31:0]      pwdata, prdata, rdat, mid;
	flash_req_s       flash_req;
	logic             flash_req_valid, flash_page_erase, rerr;
	logic [7:0]       flash_page;
	logic [15:0]      flash_rdata, w;
	logic [15:0]      mem [0:8191];
	logic [15:0]      exp_w [0:31];
	logic [12:0]      raddr;
	logic [4:0]       idx;
	int               failures, cmp_count, req_cnt, erase_cnt, stall_cnt;
	integer           seed;
	flash_iap_erase_write_read #(.PROGRAM_CYCLES(PC), .UNLOCK_CYCLES(UC)) i_flash_iap_erase_write_read (
		.clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_stall(cpu_stall), .flash_req(flash_req), .flash_req_valid(flash_req_valid),
		.flash_page_erase(flash_page_erase), .flash_page(flash_page), .flash_rdata(flash_rdata)
	);
	// ************
	// clock and flash array model
	// ************
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		if (rstn !== 1'b1)
		begin
			raddr = 13'h0000;
			// unerased words hold nonzero contents
			for (int i = 0; i < 8192; i++)
				mem[i] = 16'(i) | 16'h0001;
		end
		if (flash_req_valid === 1'b1 && flash_req.we === 1'b1)
		begin
			mem[flash_req.addr] = flash_req.wdata;
			req_cnt++;
		end
		if (flash_req_valid === 1'b1 && flash_req.we === 1'b0)
			raddr = flash_req.addr;
		if (flash_page_erase === 1'b1)
		begin
			erase_cnt++;
			`CHK(flash_page, 8'ha5)
			for (int i = 0; i < 32; i++)
				mem[{flash_page, i[4:0]}] = 16'h0000;
		end
		if (cpu_stall === 1'b1)
			stall_cnt++;
		flash_rdata <= mem[raddr];
	end
	// ************
	// bus tasks
	// ************
	task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			failures++;
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task poll(input logic [7:0] mask);
		int n;
		n = 0;
		apb(1'b0, `OFS_CONTROL, 8'h00);
		while ((rdat[7:0] & mask) != 8'h00 && n < 200)
		begin
			apb(1'b0, `OFS_CONTROL, 8'h00);
			n++;
		end
		if (n >= 200)
			failures++;
	endtask
	task unlock(input logic [7:0] last);
		apb(1'b1, `OFS_CONTROL, 8'h68);
		apb(1'b1, `OFS_KEY1_LOW, `KEY1_LOW);
		apb(1'b1, `OFS_KEY2_LOW, `KEY2_LOW);
		apb(1'b1, `OFS_KEY3_LOW, `KEY3_LOW);
		apb(1'b1, `OFS_KEY1_HIGH, `KEY1_HIGH);
		apb(1'b1, `OFS_KEY2_HIGH, `KEY2_HIGH);
		apb(1'b1, `OFS_KEY3_HIGH, last);
		apb(1'b0, `OFS_CONTROL, 8'h00);
		mid = rdat;
		repeat (UC + 8) @(posedge clk);
		apb(1'b0, `OFS_CONTROL, 8'h00);
	endtask
	task write_words(input logic [7:0] low, input int cnt);
		apb(1'b1, `OFS_TARGET_LOW, low);
		apb(1'b1, `OFS_TARGET_HIGH, 8'h14);
		for (int i = 0; i < cnt; i++)
		begin
			w = 16'($random(seed));
			exp_w[(low[4:0] + i > 31) ? 31 : low[4:0] + i] = w;
			apb(1'b1, `OFS_DATA0_LOW, w[7:0]);
			apb(1'b1, `OFS_DATA0_HIGH, w[15:8]);
		end
		req_cnt = 0;
		apb(1'b1, `OFS_CONTROL, 8'h84);
		poll(8'h04);
	endtask
	task print_verdict;
		if (failures == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		print_verdict();
	end
	// ************
	// main sequence
	// ************
	initial
	begin
		seed = 32'hd012;
		{rstn, ce, psel, penable, pwrite, paddr, pwdata} = '0;
		{failures, cmp_count, req_cnt, erase_cnt, stall_cnt} = '0;
		ce = 1'b1;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		apb(1'b1, `OFS_CONTROL, 8'h80);
		apb(1'b0, `OFS_CONTROL, 8'h00);
		`CHK(rdat[7:0], 8'h00)
		apb(1'b0, 12'h030, 8'h00);
		`CHK(rerr, 1'b1)
		apb(1'b1, `OFS_CONTROL, 8'h04);
		repeat (PC + 8) @(posedge clk);
		apb(1'b0, `OFS_CONTROL, 8'h00);
		`CHK({rdat[2], 32'(req_cnt)}, 33'h0)
		unlock(8'h41);
		`CHK(rdat[7:0] & 8'h88, 8'h00)
		unlock(`KEY3_HIGH);
		`CHK(mid[3], 1'b1)
		`CHK(rdat[7:3], 5'b11100)
		apb(1'b1, `OFS_TARGET_LOW, 8'ha7);
		apb(1'b1, `OFS_TARGET_HIGH, 8'h14);
		apb(1'b1, `OFS_CONTROL, 8'h90);
		stall_cnt = 0;
		apb(1'b1, `OFS_CONTROL, 8'h94);
		poll(8'h04);
		`CHK({rdat[2], 32'(erase_cnt)}, 33'h1)
		`CHK(stall_cnt >= PC && stall_cnt <= PC + 1, 1'b1)
		for (int i = 0; i < 32; i++)
			`CHK(mem[{8'ha5, i[4:0]}], 16'h0000)
		apb(1'b1, `OFS_CONTROL, 8'h80);
		write_words(8'ha0, 33);
		`CHK(req_cnt, 32)
		for (int i = 0; i < 32; i++)
			`CHK(mem[{8'ha5, i[4:0]}], exp_w[i])
		apb(1'b1, `OFS_BUF_CLEAR, 8'h01);
		apb(1'b0, `OFS_BUF_CLEAR, 8'h00);
		`CHK(rdat[0], 1'b1)
		for (int n = 0; n < 20 && (n == 0 || rdat[0] !== 1'b0); n++)
			apb(1'b0, `OFS_BUF_CLEAR, 8'h00);
		`CHK(rdat[0], 1'b0)
		for (int i = 0; i < 32; i++)
			exp_w[i] = 16'h0000;
		write_words(8'ha3, 2);
		for (int i = 0; i < 32; i++)
			`CHK(mem[{8'ha5, i[4:0]}], exp_w[i])
		apb(1'b1, `OFS_CONTROL, 8'h00);
		apb(1'b1, `OFS_CONTROL, 8'h94);
		repeat (PC + 8) @(posedge clk);
		apb(1'b0, `OFS_CONTROL, 8'h00);
		`CHK({rdat[7], rdat[2], 32'(erase_cnt)}, 34'h1)
		apb(1'b1, `OFS_CONTROL, 8'h30);
		apb(1'b1, `OFS_CONTROL, 8'h32);
		for (int k = 0; k < 3; k++)
		begin
			idx = (k < 2) ? 5'(3 + k) : 5'($random(seed));
			apb(1'b1, `OFS_TARGET_LOW, {3'b101, idx});
			stall_cnt = 0;
			apb(1'b1, `OFS_CONTROL, 8'h33);
			poll(8'h01);
			`CHK(stall_cnt >= 3 && stall_cnt <= 4, 1'b1)
			apb(1'b0, `OFS_DATA0_LOW, 8'h00);
			w[7:0] = rdat[7:0];
			apb(1'b0, `OFS_DATA0_HIGH, 8'h00);
			w[15:8] = rdat[7:0];
			`CHK(w, exp_w[idx])
		end
		print_verdict();
	end
endmodule
